// ==== hdl/wpm_defines.svh ====
/*
  Offsets, field positions, reset values and counts of the wake pattern
  match register bank. Assumes inclusion by bare name from hdl/.
*/
`ifndef WPM_DEFINES_SVH
`define WPM_DEFINES_SVH

// =========================================================
// Register indices (printed offsets, byte address = 4 * index)
`define WPM_IDX_P0_MASK3 8'h3a
`define WPM_IDX_P1_CRC_LO 8'h40
`define WPM_IDX_P1_CRC_HI 8'h42
`define WPM_IDX_P1_MASK0 8'h44
`define WPM_IDX_P1_MASK1 8'h46
`define WPM_IDX_P1_MASK2 8'h48
`define WPM_IDX_P1_MASK3 8'h4a
`define WPM_IDX_P2_CRC_LO 8'h50
`define WPM_IDX_P2_CRC_HI 8'h52
`define WPM_IDX_P2_MASK0 8'h54
`define WPM_IDX_P2_MASK1 8'h56
`define WPM_IDX_P2_MASK2 8'h58
`define WPM_IDX_P2_MASK3 8'h5a
`define WPM_IDX_WAKE_CTRL 8'h2a
// Own registers for event status, clear and interrupt enable
`define WPM_IDX_EVT_STATUS 8'h80
`define WPM_IDX_EVT_CLEAR 8'h81
`define WPM_IDX_EVT_ENABLE 8'h82

// =========================================================
// Fields and values
`define WPM_CTRL_P1_EN_BIT 1
`define WPM_CTRL_P2_EN_BIT 2
`define WPM_CTRL_MASK 16'h0006
`define WPM_REG_RESET 16'h0000
`define WPM_CHECK_BYTES 7'h40
`define WPM_CRC_INIT 32'hffffffff
`define WPM_CRC_POLY 32'hedb88320

`endif

// ==== hdl/wpm_pkg.sv ====
/*
  Types of the wake pattern match register bank.
  Assumes nothing of its surroundings.
*/
package wpm_pkg;
  // =========================================================
  // Per-pattern checker states
  typedef enum logic [1:0] {
    WPM_IDLE = 2'b00, // Waiting for frame start
    WPM_RUN = 2'b01, // Within the first 64 bytes
    WPM_DONE = 2'b10 // Past byte 64, waiting for frame end
  } wpm_state_t;
endpackage : wpm_pkg

// ==== hdl/wpm_crc32.sv ====
/*
  One byte step of the reflected Ethernet CRC-32.
  Assumes the caller holds the running value in its own register.
*/
`include "wpm_defines.svh"
module wpm_crc32 (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);
  // =========================================================
  // Bitwise byte update, LSB first as sent on the wire
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ `WPM_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end
endmodule : wpm_crc32

// ==== hdl/wpm_checker.sv ====
/*
  Checks one wake pattern against a received frame.
  Assumes rx bytes arrive with a start marker on byte one and a last marker.
*/
`include "wpm_defines.svh"
module wpm_checker
  import wpm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [63:0] mask,
  input wire logic [31:0] expect_crc,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_data,
  output logic hit
);
  // =========================================================
  // State
  wpm_state_t state_q;
  logic [6:0] idx_q; // Byte index within the frame
  logic [31:0] crc_q; // Running CRC
  logic [31:0] crc_next;
  logic [5:0] pos;
  logic use_byte;
  logic [31:0] crc_upd;
  logic last_check;

  // Position 0 for byte one, restarting on a start marker
  assign pos = (rx_sof) ? 6'h00 : idx_q[5:0];
  // Mask bit n selects byte n+1
  assign use_byte = mask[pos];

  wpm_crc32 u_crc (
    .crc_in(rx_sof ? `WPM_CRC_INIT : crc_q),
    .data(rx_data),
    .crc_out(crc_next)
  );

  // Skip unselected bytes entirely
  assign crc_upd = use_byte ? crc_next : (rx_sof ? `WPM_CRC_INIT : crc_q);
  // Check ends at byte 64 or a shorter frame's end
  assign last_check = (pos == 6'h3f) || rx_eof;

  // =========================================================
  // Walk the first 64 bytes, later bytes are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= WPM_IDLE;
      idx_q <= 7'h00;
      crc_q <= `WPM_CRC_INIT;
      hit <= 1'b0;
    end else begin
      hit <= 1'b0;
      if (rx_valid && (rx_sof || state_q == WPM_RUN)) begin
        crc_q <= crc_upd;
        idx_q <= {1'b0, pos} + 7'h01;
        if (last_check) begin
          // Match only while enabled, final value is complemented
          hit <= enable && ((~crc_upd) == expect_crc);
          state_q <= rx_eof ? WPM_IDLE : WPM_DONE;
        end else begin
          state_q <= WPM_RUN;
        end
      end else if (rx_valid && rx_eof) begin
        state_q <= WPM_IDLE;
      end
    end
  end
endmodule : wpm_checker

// ==== hdl/wpm_regs.sv ====
/*
  Wake pattern match register bank: APB slave, pattern 1 and 2 checkers,
  sticky wake events and interrupt.
  Assumes an APB master on pclk and a byte stream from the receive MAC.
*/
// What this block does
// - Mask word 0 bits select bytes 1-16
// - Mask word 1 bits select bytes 17-32
// - Mask word 2 bits select bytes 33-48
// - Mask word 3 bits select bytes 49-64
// - Bytes past sixty-four never checked
// - CRC only over mask-selected bytes
// - Low CRC register holds bits 15-0
// - High CRC register holds bits 31-16
// - Pattern checked only when enabled
`include "wpm_defines.svh"
module wpm_regs
  import wpm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_data,
  output logic [15:0] pattern0_mask_word3,
  output logic wake_irq
);
  // =========================================================
  // Registers
  logic [15:0] wake_control_register_q; // Pattern enables
  logic [15:0] p1_crc_lo_q, p1_crc_hi_q, p2_crc_lo_q, p2_crc_hi_q;
  logic [15:0] p0_mask3_q;
  logic [15:0] p1_mask_q [4]; // Indexed by mask word
  logic [15:0] p2_mask_q [4];
  logic [1:0] evt_status_q; // Sticky wake events
  logic [1:0] evt_enable_q; // Interrupt enables
  logic [1:0] hit;
  logic wr, rd, hit_addr;
  logic [7:0] idx;
  logic [15:0] rdata;

  // Decode the register index from the word address
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    return a[9:2];
  endfunction : reg_index

  // Merge byte strobes into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  assign idx = reg_index(paddr);
  // Zero wait states; unaligned addresses are errors
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite && !pslverr;
  assign rd = psel && !pwrite;
  assign pattern0_mask_word3 = p0_mask3_q;
  assign wake_irq = |(evt_status_q & evt_enable_q);

  // =========================================================
  // Read decode, also flags unmapped addresses
  always_comb begin
    rdata = 16'h0000;
    hit_addr = 1'b1;
    case (idx)
      `WPM_IDX_WAKE_CTRL: rdata = wake_control_register_q;
      `WPM_IDX_P0_MASK3: rdata = p0_mask3_q;
      `WPM_IDX_P1_CRC_LO: rdata = p1_crc_lo_q;
      `WPM_IDX_P1_CRC_HI: rdata = p1_crc_hi_q;
      `WPM_IDX_P1_MASK0: rdata = p1_mask_q[0];
      `WPM_IDX_P1_MASK1: rdata = p1_mask_q[1];
      `WPM_IDX_P1_MASK2: rdata = p1_mask_q[2];
      `WPM_IDX_P1_MASK3: rdata = p1_mask_q[3];
      `WPM_IDX_P2_CRC_LO: rdata = p2_crc_lo_q;
      `WPM_IDX_P2_CRC_HI: rdata = p2_crc_hi_q;
      `WPM_IDX_P2_MASK0: rdata = p2_mask_q[0];
      `WPM_IDX_P2_MASK1: rdata = p2_mask_q[1];
      `WPM_IDX_P2_MASK2: rdata = p2_mask_q[2];
      `WPM_IDX_P2_MASK3: rdata = p2_mask_q[3];
      `WPM_IDX_EVT_STATUS: rdata = {14'h0000, evt_status_q};
      `WPM_IDX_EVT_CLEAR: rdata = 16'h0000; // Write only
      `WPM_IDX_EVT_ENABLE: rdata = {14'h0000, evt_enable_q};
      default: hit_addr = 1'b0;
    endcase
  end

  // Error on unmapped or out-of-range access, in the access phase
  // Byte offsets inside a word are refused, since each register is one word
  assign pslverr = psel && penable &&
      (!hit_addr || paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00);

  // =========================================================
  // Read data register, captured on the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd && !penable) begin
      prdata <= {16'h0000, rdata};
    end
  end

  // =========================================================
  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_control_register_q <= `WPM_REG_RESET;
      p0_mask3_q <= `WPM_REG_RESET;
      p1_crc_lo_q <= `WPM_REG_RESET;
      p1_crc_hi_q <= `WPM_REG_RESET;
      p2_crc_lo_q <= `WPM_REG_RESET;
      p2_crc_hi_q <= `WPM_REG_RESET;
      evt_enable_q <= 2'b00;
      for (int i = 0; i < 4; i++) begin
        p1_mask_q[i] <= `WPM_REG_RESET;
        p2_mask_q[i] <= `WPM_REG_RESET;
      end
    end else if (wr) begin
      case (idx)
        `WPM_IDX_WAKE_CTRL: wake_control_register_q <=
            merge(wake_control_register_q, pwdata, pstrb) & `WPM_CTRL_MASK;
        `WPM_IDX_P0_MASK3: p0_mask3_q <= merge(p0_mask3_q, pwdata, pstrb);
        `WPM_IDX_P1_CRC_LO: p1_crc_lo_q <= merge(p1_crc_lo_q, pwdata, pstrb);
        `WPM_IDX_P1_CRC_HI: p1_crc_hi_q <= merge(p1_crc_hi_q, pwdata, pstrb);
        `WPM_IDX_P1_MASK0: p1_mask_q[0] <= merge(p1_mask_q[0], pwdata, pstrb);
        `WPM_IDX_P1_MASK1: p1_mask_q[1] <= merge(p1_mask_q[1], pwdata, pstrb);
        `WPM_IDX_P1_MASK2: p1_mask_q[2] <= merge(p1_mask_q[2], pwdata, pstrb);
        `WPM_IDX_P1_MASK3: p1_mask_q[3] <= merge(p1_mask_q[3], pwdata, pstrb);
        `WPM_IDX_P2_CRC_LO: p2_crc_lo_q <= merge(p2_crc_lo_q, pwdata, pstrb);
        `WPM_IDX_P2_CRC_HI: p2_crc_hi_q <= merge(p2_crc_hi_q, pwdata, pstrb);
        `WPM_IDX_P2_MASK0: p2_mask_q[0] <= merge(p2_mask_q[0], pwdata, pstrb);
        `WPM_IDX_P2_MASK1: p2_mask_q[1] <= merge(p2_mask_q[1], pwdata, pstrb);
        `WPM_IDX_P2_MASK2: p2_mask_q[2] <= merge(p2_mask_q[2], pwdata, pstrb);
        `WPM_IDX_P2_MASK3: p2_mask_q[3] <= merge(p2_mask_q[3], pwdata, pstrb);
        `WPM_IDX_EVT_ENABLE: evt_enable_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // =========================================================
  // Sticky events; a hit in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_q <= 2'b00;
    end else begin
      if (wr && idx == `WPM_IDX_EVT_CLEAR) begin
        evt_status_q <= (evt_status_q & ~pwdata[1:0]) | hit;
      end else begin
        evt_status_q <= evt_status_q | hit;
      end
    end
  end

  // =========================================================
  // Pattern checkers; mask words concatenate with word 0 lowest
  wpm_checker u_chk1 (
    .pclk(pclk),
    .presetn(presetn),
    .enable(wake_control_register_q[`WPM_CTRL_P1_EN_BIT]),
    .mask({p1_mask_q[3], p1_mask_q[2], p1_mask_q[1], p1_mask_q[0]}),
    .expect_crc({p1_crc_hi_q, p1_crc_lo_q}),
    .rx_valid(rx_valid),
    .rx_sof(rx_sof),
    .rx_eof(rx_eof),
    .rx_data(rx_data),
    .hit(hit[0])
  );

  wpm_checker u_chk2 (
    .pclk(pclk),
    .presetn(presetn),
    .enable(wake_control_register_q[`WPM_CTRL_P2_EN_BIT]),
    .mask({p2_mask_q[3], p2_mask_q[2], p2_mask_q[1], p2_mask_q[0]}),
    .expect_crc({p2_crc_hi_q, p2_crc_lo_q}),
    .rx_valid(rx_valid),
    .rx_sof(rx_sof),
    .rx_eof(rx_eof),
    .rx_data(rx_data),
    .hit(hit[1])
  );

  // =========================================================
  // Assertions
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    wake_irq == |(evt_status_q & evt_enable_q)) else $error("irq level wrong");
  a_hit_sticks: assert property (@(posedge pclk) disable iff (!presetn)
    hit[0] |=> evt_status_q[0]) else $error("event 1 not latched");
  a_hit2_sticks: assert property (@(posedge pclk) disable iff (!presetn)
    hit[1] |=> evt_status_q[1]) else $error("event 2 not latched");
  a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !wake_control_register_q[`WPM_CTRL_P1_EN_BIT] |=> !hit[0]) else $error("hit while off");
  a_disabled2_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !wake_control_register_q[`WPM_CTRL_P2_EN_BIT] |=> !hit[1]) else $error("hit2 while off");
  a_crc_lo_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == `WPM_IDX_P1_CRC_LO && pstrb[1:0] == 2'b11 |=> p1_crc_lo_q == $past(pwdata[15:0]))
    else $error("crc low write lost");
  a_crc_hi_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == `WPM_IDX_P2_CRC_HI && pstrb[1:0] == 2'b11 |=> p2_crc_hi_q == $past(pwdata[15:0]))
    else $error("crc high write lost");
  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == `WPM_IDX_P1_MASK3 && pstrb[1:0] == 2'b11 |=> p1_mask_q[3] == $past(pwdata[15:0]))
    else $error("mask write lost");
  c_hit1: cover property (@(posedge pclk) disable iff (!presetn) hit[0]);
  c_hit2: cover property (@(posedge pclk) disable iff (!presetn) hit[1]);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(wake_irq));
endmodule : wpm_regs

// ==== verif/wpm_rx_model.sv ====
/*
  Receive MAC model: hands frames to the wake matcher one byte a cycle.
  Assumes it shares pclk with the bench and is only used after reset.
*/
module wpm_rx_model (
  input wire logic pclk,
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_eof,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================================
  // Idle lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_data = 8'h00;
  end
  // =========================================================
  // Frame sender: no gaps, markers on first and last byte
  task automatic send_frame(input logic [7:0] frm [$]);
    for (int i = 0; i < frm.size(); i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i == frm.size() - 1);
      rx_data <= frm[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_eof <= 1'b0;
    // Stale byte inverted so a missed strobe check cannot see a valid copy
    rx_data <= ~frm[frm.size() - 1];
  endtask : send_frame
endmodule : wpm_rx_model

// ==== verif/wpm_regs_tb.sv ====
/*
  Self-checking bench of the wake pattern match register bank.
  Assumes the design sources and wpm_defines.svh are on the include path.
*/
`include "wpm_defines.svh"
module wpm_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================================
  // Stimulus and observed signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, rx_sof, rx_eof, wake_irq;
  logic [7:0] rx_data;
  logic [15:0] p0_mask;
  int fail_count = 0;
  int total_checks = 0;
  logic [7:0] frame_q [$]; // Frame shared by all match tests
  logic [7:0] reg_idx [13] = '{`WPM_IDX_P0_MASK3, `WPM_IDX_P1_CRC_LO, `WPM_IDX_P1_CRC_HI,
    `WPM_IDX_P1_MASK0, `WPM_IDX_P1_MASK1, `WPM_IDX_P1_MASK2, `WPM_IDX_P1_MASK3,
    `WPM_IDX_P2_CRC_LO, `WPM_IDX_P2_CRC_HI, `WPM_IDX_P2_MASK0, `WPM_IDX_P2_MASK1,
    `WPM_IDX_P2_MASK2, `WPM_IDX_P2_MASK3};
  logic [31:0] rd;
  logic err;
  logic [63:0] m1;
  logic [31:0] c1, c2;
  logic [15:0] wv;
  // =========================================================
  // Clock, 25 ns period
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  wpm_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_data(rx_data), .pattern0_mask_word3(p0_mask), .wake_irq(wake_irq));
  wpm_rx_model rx (.pclk(pclk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_data(rx_data));
  // =========================================================
  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // APB transfer; called just after a rising edge, leaves one idle cycle after
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    pstrb <= 4'h3;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Expected Ethernet CRC over mask-selected bytes among the first 64
  function automatic logic [31:0] crc_of(input logic [63:0] m);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 0; i < 64; i++) begin
      if (m[i]) begin
        c = c ^ {24'h000000, frame_q[i]};
        for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 32'hedb8_8320) : (c >> 1);
      end
    end
    return ~c;
  endfunction : crc_of
  // Load CRC halves and mask words of one pattern (base is its low CRC index)
  task automatic load_pattern(input logic [7:0] base, input logic [63:0] m,
                              input logic [31:0] c);
    apb(1'b1, base, c[15:0]);
    apb(1'b1, base + 8'h02, c[31:16]);
    for (int k = 0; k < 4; k++) apb(1'b1, base + 8'h04 + 8'(2 * k), m[16 * k +: 16]);
  endtask : load_pattern
  // Send the frame, let the status bit land, read status
  task automatic frame_and_status(input logic [1:0] want);
    rx.send_frame(frame_q);
    repeat (2) @(posedge pclk);
    apb(1'b0, `WPM_IDX_EVT_STATUS, 16'h0000);
    check(rd, {30'h0, want});
  endtask : frame_and_status
  // =========================================================
  // Watchdog
  initial begin
    #(25ns * 20000);
    fail_count++;
    complete_run();
  end
  // =========================================================
  // Main sequence
  initial begin
    void'($urandom(15));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, then random write and read back of the thirteen CRC and mask registers
    foreach (reg_idx[i]) begin
      apb(1'b0, reg_idx[i], 16'h0000);
      check(rd, 32'h0000_0000);
      wv = 16'($urandom());
      apb(1'b1, reg_idx[i], wv);
      apb(1'b0, reg_idx[i], 16'h0000);
      check(rd, {16'h0000, wv});
      if (i == 0) check({16'h0000, p0_mask}, {16'h0000, wv});
    end
    // Reserved index refused, reads zero
    apb(1'b1, 8'h3c, 16'hffff);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h3c, 16'h0000);
    check({rd[31:1], err}, 32'h1);
    $display("test registers done");
    // Random frame longer than 64 bytes; pattern 2 uses only bytes 1 and 64
    repeat (80) frame_q.push_back(8'($urandom()));
    m1 = {32'($urandom()), 32'($urandom())};
    c1 = crc_of(m1);
    c2 = crc_of(64'h8000_0000_0000_0001);
    load_pattern(`WPM_IDX_P1_CRC_LO, m1, c1);
    load_pattern(`WPM_IDX_P2_CRC_LO, 64'h8000_0000_0000_0001, c2);
    apb(1'b1, `WPM_IDX_WAKE_CTRL, 16'h0006);
    apb(1'b1, `WPM_IDX_EVT_ENABLE, 16'h0003);
    frame_and_status(2'b11);
    check({31'h0, wake_irq}, 32'h1);
    $display("test match done");
    // Clear, then a wrong low CRC bit on pattern 1
    apb(1'b1, `WPM_IDX_EVT_CLEAR, 16'h0003);
    check({31'h0, wake_irq}, 32'h0);
    apb(1'b1, `WPM_IDX_P1_CRC_LO, c1[15:0] ^ 16'h0001);
    frame_and_status(2'b10);
    $display("test mismatch done");
    // Pattern 2 disabled, pattern 1 restored, its interrupt masked
    apb(1'b1, `WPM_IDX_EVT_CLEAR, 16'h0003);
    apb(1'b1, `WPM_IDX_P1_CRC_LO, c1[15:0]);
    apb(1'b1, `WPM_IDX_WAKE_CTRL, 16'h0002);
    apb(1'b1, `WPM_IDX_EVT_ENABLE, 16'h0002);
    frame_and_status(2'b01);
    check({31'h0, wake_irq}, 32'h0);
    $display("test enable done");
    complete_run();
  end
endmodule : wpm_regs_tb
